/* logic/umf_pkg.sv */
package umf_pkg;
	localparam logic [5:0]  OFF_CTRL     = 6'h00;
	localparam logic [5:0]  OFF_MP       = 6'h04;
	localparam logic [5:0]  OFF_RTS      = 6'h08;
	localparam logic [5:0]  OFF_RX_TRIG  = 6'h0C;
	localparam logic [5:0]  OFF_TX_TRIG  = 6'h10;
	localparam logic [5:0]  OFF_RX_STAT  = 6'h14;
	localparam logic [5:0]  OFF_RX_MASK  = 6'h18;
	localparam logic [5:0]  OFF_TX_STAT  = 6'h1C;
	localparam logic [5:0]  OFF_TX_MASK  = 6'h20;
	localparam logic [5:0]  OFF_TX_DATA  = 6'h24;
	localparam logic [5:0]  OFF_RX_DATA  = 6'h28;
	localparam logic [5:0]  OFF_FIFO     = 6'h2C;
	localparam int          C_MP_EN      = 0;
	localparam int          C_MP_KEEP    = 1;
	localparam int          C_BYTE       = 2;
	localparam int          C_CTS_EN     = 3;
	localparam int          C_CTS_LVL    = 4;
	localparam int          C_RTS_LVL    = 5;
	localparam int          C_IRQ_EN     = 6;
	localparam int          RX_LVL       = 0;
	localparam int          RX_NE        = 1;
	localparam int          RX_FULL      = 2;
	localparam int          RX_OVR       = 3;
	localparam int          RX_UNDR      = 4;
	localparam int          RX_PAR       = 5;
	localparam int          TX_LVL       = 0;
	localparam int          TX_NF        = 1;
	localparam int          TX_EMPTY     = 2;
	localparam int          TX_OVR       = 3;
	localparam int          TX_UNDR      = 4;
	localparam int          TX_DONE      = 5;
	localparam int          TX_NACK      = 6;
	localparam int          TX_ARB       = 7;
	localparam logic [4:0]  DEPTH_WORD   = 5'h08;
	localparam logic [4:0]  DEPTH_BYTE   = 5'h10;
	localparam logic [3:0]  PMASK_WORD   = 4'h7;
	localparam logic [3:0]  PMASK_BYTE   = 4'hF;
	localparam logic [6:0]  CTRL_RST     = 7'h00;
	localparam logic [7:0]  MASK8_RST    = 8'h00;
	localparam logic [3:0]  LEVEL_RST    = 4'h0;
	localparam logic        RTS_PIN_RST  = 1'b1;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

	typedef struct packed {
		logic        awvalid;
		logic [31:0] awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [31:0] araddr;
		logic        rready;
	} umf_axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} umf_axi_rsp_t;

	typedef struct packed {
		logic       valid;
		logic [8:0] word;
		logic       parity_err;
	} umf_rx_in_t;

	typedef struct packed {
		logic pull;
		logic done;
		logic nack;
		logic arb_lost;
	} umf_tx_evt_t;
endpackage : umf_pkg

/* logic/umf_uart_ctrl.sv */
// Implementation choices: the register offsets and the AXI4-Lite slave port.
module umf_uart_ctrl
	import umf_pkg::*;
(
	input  wire logic         mclk,
	input  wire logic         rst,
	input  wire logic         ce,
	input  wire umf_axi_req_t axi_req,
	output umf_axi_rsp_t      axi_rsp,
	input  wire umf_rx_in_t   rx_in,
	input  wire umf_tx_evt_t  tx_evt,
	input  wire logic         cts_in,
	output logic              rts_out,
	output logic [8:0]        tx_word,
	output logic              tx_load,
	output logic              irq
);
	logic [6:0]  ctrl_r;
	logic [7:0]  mp_node_address, mp_compare_mask;
	logic [3:0]  request_to_send_threshold, rx_level_trigger, tx_level_trigger;
	logic [5:0]  rx_stat_r, rx_irq_mask;
	logic [7:0]  tx_stat_r, tx_irq_mask;
	logic        aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
	logic [5:0]  aw_addr_r;
	logic [31:0] w_data_r, rdata_r, rd_mux, wmask;
	logic [3:0]  w_strb_r;
	logic [1:0]  bresp_r, rresp_r;
	logic        wr_go, rd_go, wr_hit, rd_hit;
	logic [5:0]  rd_addr;
	logic [8:0]  rx_mem [16];
	logic [8:0]  tx_mem [16];
	logic [3:0]  rx_wp_r, rx_rp_r, tx_wp_r, tx_rp_r, pmask;
	logic [4:0]  rx_cnt_r, tx_cnt_r, lim;
	logic        rx_full, rx_empty, tx_full, tx_empty;
	logic        mp_mode_en, mp_keep_matched_addr, byte_fifo_en, irq_master_en;
	logic        clear_to_send_gate_en, clear_to_send_level, request_to_send_level;
	logic        addr_match, rx_want, rx_push, rx_ovr, rx_rd, rx_pop, rx_undr;
	logic        tx_try, tx_push, tx_ovr, cts_ok, tx_pop, tx_undr, rts_act;
	logic        mp_open_r, rts_out_r, tx_load_r, irq_r;
	logic [8:0]  tx_word_r;
	logic [5:0]  rx_set, rx_clr;
	logic [7:0]  tx_set, tx_clr;

	assign mp_mode_en            = ctrl_r[C_MP_EN];
	assign mp_keep_matched_addr  = ctrl_r[C_MP_KEEP];
	assign byte_fifo_en          = ctrl_r[C_BYTE];
	assign clear_to_send_gate_en = ctrl_r[C_CTS_EN];
	assign clear_to_send_level   = ctrl_r[C_CTS_LVL];
	assign request_to_send_level = ctrl_r[C_RTS_LVL];
	assign irq_master_en         = ctrl_r[C_IRQ_EN];

	// Bus handshakes
	assign wr_go   = ce && aw_hold_r && w_hold_r && !bvalid_r;
	assign rd_go   = ce && axi_req.arvalid && !rvalid_r;
	assign rd_addr = axi_req.araddr[5:0];
	assign axi_rsp.awready = ce && !aw_hold_r;
	assign axi_rsp.wready  = ce && !w_hold_r;
	assign axi_rsp.bvalid  = bvalid_r;
	assign axi_rsp.bresp   = bresp_r;
	assign axi_rsp.arready = ce && !rvalid_r;
	assign axi_rsp.rvalid  = rvalid_r;
	assign axi_rsp.rdata   = rdata_r;
	assign axi_rsp.rresp   = rresp_r;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_lane
			assign wmask[gi*8 +: 8] = {8{w_strb_r[gi]}};
		end
	endgenerate

	always_comb begin
		wr_hit = (aw_addr_r[1:0] == 2'h0) && (aw_addr_r <= OFF_TX_DATA);
		rd_hit = 1'b1;
		rd_mux = 32'h0000_0000;
		case (rd_addr)
			OFF_CTRL:    rd_mux = {25'h000_0000, ctrl_r};
			OFF_MP:      rd_mux = {16'h0000, mp_compare_mask, mp_node_address};
			OFF_RTS:     rd_mux = {28'h000_0000, request_to_send_threshold};
			OFF_RX_TRIG: rd_mux = {28'h000_0000, rx_level_trigger};
			OFF_TX_TRIG: rd_mux = {28'h000_0000, tx_level_trigger};
			OFF_RX_STAT: rd_mux = {26'h000_0000, rx_stat_r};
			OFF_RX_MASK: rd_mux = {26'h000_0000, rx_irq_mask};
			OFF_TX_STAT: rd_mux = {24'h00_0000, tx_stat_r};
			OFF_TX_MASK: rd_mux = {24'h00_0000, tx_irq_mask};
			OFF_TX_DATA: rd_mux = 32'h0000_0000;
			OFF_RX_DATA: rd_mux = {23'h00_0000, rx_mem[rx_rp_r]};
			OFF_FIFO:    rd_mux = {14'h0000, mp_open_r, rts_out_r, 3'h0, tx_cnt_r, 3'h0, rx_cnt_r};
			default:     rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			aw_hold_r <= 1'b0;
			w_hold_r  <= 1'b0;
			aw_addr_r <= 6'h00;
			w_data_r  <= 32'h0000_0000;
			w_strb_r  <= 4'h0;
			bvalid_r  <= 1'b0;
			bresp_r   <= RESP_OKAY;
		end else if (ce) begin
			if (axi_req.awvalid && !aw_hold_r) begin
				aw_hold_r <= 1'b1;
				aw_addr_r <= axi_req.awaddr[5:0];
			end
			if (axi_req.wvalid && !w_hold_r) begin
				w_hold_r <= 1'b1;
				w_data_r <= axi_req.wdata;
				w_strb_r <= axi_req.wstrb;
			end
			if (wr_go) begin
				aw_hold_r <= 1'b0;
				w_hold_r  <= 1'b0;
				bvalid_r  <= 1'b1;
				bresp_r   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_r && axi_req.bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h0000_0000;
			rresp_r  <= RESP_OKAY;
		end else if (ce) begin
			if (rd_go) begin
				rvalid_r <= 1'b1;
				rdata_r  <= rd_mux;
				rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (rvalid_r && axi_req.rready) begin
				rvalid_r <= 1'b0;
			end
		end
	end

	// Configuration registers, byte lanes honoured
	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrl_r                    <= CTRL_RST;
			mp_node_address           <= MASK8_RST;
			mp_compare_mask           <= MASK8_RST;
			request_to_send_threshold <= LEVEL_RST;
			rx_level_trigger          <= LEVEL_RST;
			tx_level_trigger          <= LEVEL_RST;
			rx_irq_mask               <= MASK8_RST[5:0];
			tx_irq_mask               <= MASK8_RST;
		end else if (wr_go) begin
			case (aw_addr_r)
				OFF_CTRL: if (w_strb_r[0]) ctrl_r <= w_data_r[6:0];
				OFF_MP: begin
					if (w_strb_r[0]) mp_node_address <= w_data_r[7:0];
					if (w_strb_r[1]) mp_compare_mask <= w_data_r[15:8];
				end
				OFF_RTS:     if (w_strb_r[0]) request_to_send_threshold <= w_data_r[3:0];
				OFF_RX_TRIG: if (w_strb_r[0]) rx_level_trigger <= w_data_r[3:0];
				OFF_TX_TRIG: if (w_strb_r[0]) tx_level_trigger <= w_data_r[3:0];
				OFF_RX_MASK: if (w_strb_r[0]) rx_irq_mask <= w_data_r[5:0];
				OFF_TX_MASK: if (w_strb_r[0]) tx_irq_mask <= w_data_r[7:0];
				default: ;
			endcase
		end
	end

	// Receive path with address filtering
	assign pmask      = byte_fifo_en ? PMASK_BYTE : PMASK_WORD;
	assign lim        = byte_fifo_en ? DEPTH_BYTE : DEPTH_WORD;
	assign rx_full    = rx_cnt_r >= lim;
	assign rx_empty   = rx_cnt_r == 5'h00;
	assign tx_full    = tx_cnt_r >= lim;
	assign tx_empty   = tx_cnt_r == 5'h00;
	assign addr_match = ((rx_in.word[7:0] ^ mp_node_address) & mp_compare_mask) == 8'h00;
	always_comb begin
		rx_want = rx_in.valid;
		if (mp_mode_en) begin
			rx_want = rx_in.valid && (rx_in.word[8] ? (addr_match && mp_keep_matched_addr) : mp_open_r);
		end
	end
	assign rx_push = rx_want && !rx_full;
	assign rx_ovr  = rx_want && rx_full;
	assign rx_rd   = rd_go && rd_addr == OFF_RX_DATA;
	assign rx_pop  = rx_rd && !rx_empty;
	assign rx_undr = rx_rd && rx_empty;

	always_ff @(posedge mclk) begin
		if (rst) begin
			mp_open_r <= 1'b0;
		end else if (ce) begin
			if (!mp_mode_en) mp_open_r <= 1'b0;
			else if (rx_in.valid && rx_in.word[8]) mp_open_r <= addr_match;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			rx_wp_r  <= 4'h0;
			rx_rp_r  <= 4'h0;
			rx_cnt_r <= 5'h00;
		end else if (ce) begin
			if (rx_push) begin
				rx_mem[rx_wp_r] <= rx_in.word;
				rx_wp_r <= (rx_wp_r + 4'h1) & pmask;
			end
			if (rx_pop) rx_rp_r <= (rx_rp_r + 4'h1) & pmask;
			rx_cnt_r <= rx_cnt_r + 5'(rx_push) - 5'(rx_pop);
		end
	end

	// Transmit path with clear-to-send gating
	assign tx_try  = wr_go && aw_addr_r == OFF_TX_DATA && w_strb_r[0];
	assign tx_push = tx_try && !tx_full;
	assign tx_ovr  = tx_try && tx_full;
	assign cts_ok  = !clear_to_send_gate_en || (cts_in == clear_to_send_level);
	assign tx_pop  = tx_evt.pull && cts_ok && !tx_empty;
	assign tx_undr = tx_evt.pull && cts_ok && tx_empty;

	always_ff @(posedge mclk) begin
		if (rst) begin
			tx_wp_r   <= 4'h0;
			tx_rp_r   <= 4'h0;
			tx_cnt_r  <= 5'h00;
			tx_word_r <= 9'h000;
			tx_load_r <= 1'b0;
		end else if (ce) begin
			if (tx_push) begin
				tx_mem[tx_wp_r] <= w_data_r[8:0];
				tx_wp_r <= (tx_wp_r + 4'h1) & pmask;
			end
			tx_load_r <= tx_pop;
			if (tx_pop) begin
				tx_word_r <= tx_mem[tx_rp_r];
				tx_rp_r   <= (tx_rp_r + 4'h1) & pmask;
			end
			tx_cnt_r <= tx_cnt_r + 5'(tx_push) - 5'(tx_pop);
		end
	end

	// Flow control output
	assign rts_act = (request_to_send_threshold != 4'h0) && ({1'b0, request_to_send_threshold} > rx_cnt_r);
	always_ff @(posedge mclk) begin
		if (rst) rts_out_r <= RTS_PIN_RST;
		else if (ce) rts_out_r <= request_to_send_level ? rts_act : !rts_act;
	end

	// Sticky event status, set wins over write-one-to-clear
	assign rx_set = {rx_in.valid && rx_in.parity_err, rx_undr, rx_ovr, rx_full, !rx_empty,
		rx_cnt_r > {1'b0, rx_level_trigger}};
	assign tx_set = {tx_evt.arb_lost, tx_evt.nack, tx_evt.done, tx_undr, tx_ovr, tx_empty, !tx_full,
		tx_cnt_r < {1'b0, tx_level_trigger}};
	assign rx_clr = (wr_go && aw_addr_r == OFF_RX_STAT) ? (w_data_r[5:0] & wmask[5:0]) : 6'h00;
	assign tx_clr = (wr_go && aw_addr_r == OFF_TX_STAT) ? (w_data_r[7:0] & wmask[7:0]) : 8'h00;

	always_ff @(posedge mclk) begin
		if (rst) begin
			rx_stat_r <= 6'h00;
			tx_stat_r <= 8'h00;
			irq_r     <= 1'b0;
		end else if (ce) begin
			rx_stat_r <= (rx_stat_r & ~rx_clr) | rx_set;
			tx_stat_r <= (tx_stat_r & ~tx_clr) | tx_set;
			irq_r     <= irq_master_en && |{rx_stat_r & rx_irq_mask, tx_stat_r & tx_irq_mask};
		end
	end

	assign rts_out = rts_out_r;
	assign tx_word = tx_word_r;
	assign tx_load = tx_load_r;
	assign irq     = irq_r;

	chk_mp_mismatch_drop: assert property (@(posedge mclk) disable iff (rst)
		(rx_in.valid && mp_mode_en && rx_in.word[8] && !addr_match) |-> !rx_push)
		else $error("mismatched address word stored");
	chk_mp_off_store: assert property (@(posedge mclk) disable iff (rst)
		(rx_in.valid && !mp_mode_en && !rx_full) |-> rx_push)
		else $error("word lost outside multiprocessor mode");
	chk_mp_match_open: assert property (@(posedge mclk) disable iff (rst)
		(ce && rx_in.valid && mp_mode_en && rx_in.word[8] && addr_match && !mp_keep_matched_addr)
		|-> !rx_push ##1 mp_open_r)
		else $error("matched address handling wrong");
	chk_rts_level: assert property (@(posedge mclk) disable iff (rst)
		ce |=> ((rts_out_r == $past(request_to_send_level)) ==
		($past(request_to_send_threshold) != 4'h0 && {1'b0, $past(request_to_send_threshold)} > $past(rx_cnt_r))))
		else $error("rts level does not follow fill");
	chk_rts_off: assert property (@(posedge mclk) disable iff (rst)
		(ce && request_to_send_threshold == 4'h0) |=> rts_out_r != $past(request_to_send_level))
		else $error("rts active with zero threshold");
	chk_cts_block: assert property (@(posedge mclk) disable iff (rst)
		(ce && tx_evt.pull && clear_to_send_gate_en && cts_in != clear_to_send_level) |=> !tx_load_r)
		else $error("frame started without cts");
	chk_fifo_depth: assert property (@(posedge mclk) disable iff (rst)
		(rx_push || tx_push) |-> (rx_push ? rx_cnt_r : tx_cnt_r) < lim)
		else $error("fifo pushed beyond depth");
	chk_rx_overrun: assert property (@(posedge mclk) disable iff (rst)
		(ce && (rx_ovr || rx_undr)) |=> rx_stat_r[RX_OVR] || rx_stat_r[RX_UNDR])
		else $error("rx overrun or underrun not flagged");
	chk_rx_level: assert property (@(posedge mclk) disable iff (rst)
		(ce && rx_cnt_r > {1'b0, rx_level_trigger}) |=> rx_stat_r[RX_LVL])
		else $error("rx level event missing");
	chk_tx_underrun: assert property (@(posedge mclk) disable iff (rst)
		(ce && tx_evt.pull && cts_ok && tx_empty) |=> tx_stat_r[TX_UNDR] && !tx_load_r)
		else $error("tx underrun not flagged");
	chk_irq_out: assert property (@(posedge mclk) disable iff (rst)
		ce |=> irq == ($past(irq_master_en) &&
		|{$past(rx_stat_r) & $past(rx_irq_mask), $past(tx_stat_r) & $past(tx_irq_mask)}))
		else $error("irq output mismatch");
endmodule : umf_uart_ctrl

/* verif/umf_peer.sv */
module umf_peer
	import umf_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic [8:0] tx_word,
	input  wire logic       tx_load,
	output umf_rx_in_t      rx_in,
	output umf_tx_evt_t     tx_evt
);
	timeunit 1ns;
	timeprecision 1ns;
	int         loads;
	logic [8:0] last;

	initial begin
		rx_in = '0;
		tx_evt = '0;
		loads = 0;
		last = '0;
	end

	always @(posedge mclk) begin
		if (tx_load === 1'b1) begin
			loads <= loads + 1;
			last <= tx_word;
		end
	end

	task automatic send(input logic [8:0] w, input logic pe);
		@(posedge mclk);
		rx_in <= '{valid: 1'b1, word: w, parity_err: pe};
		@(posedge mclk);
		rx_in <= '{valid: 1'b0, word: ~w, parity_err: 1'b0};
	endtask : send

	task automatic evt(input logic [3:0] b);
		@(posedge mclk);
		tx_evt <= umf_tx_evt_t'(b);
		@(posedge mclk);
		tx_evt <= '0;
	endtask : evt
endmodule : umf_peer

/* verif/umf_uart_ctrl_tb.sv */
module umf_uart_ctrl_tb
	import umf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic         mclk;
	logic         rst;
	logic         ce;
	logic         cts_in;
	umf_axi_req_t req;
	umf_axi_rsp_t rsp;
	umf_rx_in_t   rx_in;
	umf_tx_evt_t  tx_evt;
	logic         rts_out;
	logic         tx_load;
	logic         irq;
	logic [8:0]   tx_word;
	logic [31:0]  d;
	int           fails;
	int           compares;

	umf_uart_ctrl u_dut (.mclk(mclk), .rst(rst), .ce(ce), .axi_req(req), .axi_rsp(rsp), .rx_in(rx_in),
		.tx_evt(tx_evt), .cts_in(cts_in), .rts_out(rts_out), .tx_word(tx_word), .tx_load(tx_load), .irq(irq));
	umf_peer u_peer (.mclk(mclk), .tx_word(tx_word), .tx_load(tx_load), .rx_in(rx_in), .tx_evt(tx_evt));

	always #50 mclk = ~mclk;

	task automatic finish_test();
		if (fails == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : finish_test

	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			fails++;
			$display("FAIL %0t got %h exp %h", $time, g, e);
		end
	endtask : cmp

	task automatic nx(input int n);
		repeat (n) @(negedge mclk);
	endtask : nx

	task automatic to();
		fails++;
		$display("FAIL %0t bus wait ran out", $time);
		finish_test();
	endtask : to

	task automatic wr(input logic [5:0] a, input logic [31:0] v);
		logic aw, w, b;
		logic [1:0] r;
		int n;
		@(posedge mclk);
		req.awaddr <= {26'h0, a};
		req.wdata <= v;
		req.wstrb <= 4'hF;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		b = 1'b0;
		n = 0;
		while (!b && n < 40) begin
			@(negedge mclk);
			aw = rsp.awready;
			w = rsp.wready;
			b = rsp.bvalid;
			r = rsp.bresp;
			n++;
			@(posedge mclk);
			if (aw) req.awvalid <= 1'b0;
			if (w) req.wvalid <= 1'b0;
		end
		req.bready <= 1'b0;
		if (!b) to();
		cmp(32'(r), 32'((a > OFF_TX_DATA) ? RESP_SLVERR : RESP_OKAY));
	endtask : wr

	task automatic rd(input logic [5:0] a, input logic [1:0] er, output logic [31:0] q);
		logic ar, r;
		logic [1:0] rr;
		int n;
		@(posedge mclk);
		req.araddr <= {26'h0, a};
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		r = 1'b0;
		n = 0;
		while (!r && n < 40) begin
			@(negedge mclk);
			ar = rsp.arready;
			r = rsp.rvalid;
			q = rsp.rdata;
			rr = rsp.rresp;
			n++;
			@(posedge mclk);
			if (ar) req.arvalid <= 1'b0;
		end
		req.rready <= 1'b0;
		if (!r) to();
		cmp(32'(rr), 32'(er));
	endtask : rd

	task automatic creg(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
		rd(a, RESP_OKAY, d);
		cmp(d & m, e);
	endtask : creg

	task automatic rxq(input logic [8:0] q[$]);
		foreach (q[i]) u_peer.send(q[i], 1'b0);
	endtask : rxq

	task automatic txp(input int e);
		u_peer.evt(4'h8);
		nx(2);
		cmp(u_peer.loads, e);
	endtask : txp

	task automatic t_reset();
		cmp(rts_out, RTS_PIN_RST);
		creg(OFF_CTRL, 32'hFF, 32'(CTRL_RST));
		rd(6'h30, RESP_SLVERR, d);
		cmp(d, 32'h0);
	endtask : t_reset

	task automatic t_rts();
		wr(OFF_RTS, 32'h2);
		nx(2);
		cmp(rts_out, 1'b0);
		rxq('{9'h0A5, 9'h13C});
		nx(2);
		cmp(rts_out, 1'b1);
		wr(OFF_CTRL, 32'h20);
		wr(OFF_RTS, 32'h7);
		nx(2);
		cmp(rts_out, 1'b1);
		wr(OFF_RTS, 32'h0);
		nx(2);
		cmp(rts_out, 1'b0);
		creg(OFF_RX_DATA, 32'h1FF, 32'h0A5);
		creg(OFF_RX_DATA, 32'h1FF, 32'h13C);
		wr(OFF_CTRL, 32'h0);
	endtask : t_rts

	task automatic t_ovf();
		for (int i = 0; i < 9; i++) u_peer.send(9'(i + 1), 1'b0);
		creg(OFF_FIFO, 32'h1F, 32'(DEPTH_WORD));
		creg(OFF_RX_STAT, 32'h1C, 32'h0C);
		for (int i = 0; i < 8; i++) creg(OFF_RX_DATA, 32'h1FF, 32'(i + 1));
		rd(OFF_RX_DATA, RESP_OKAY, d);
		creg(OFF_RX_STAT, 32'h10, 32'h10);
		wr(OFF_RX_STAT, 32'h3F);
		creg(OFF_RX_STAT, 32'h3F, 32'h0);
	endtask : t_ovf

	task automatic t_mp();
		wr(OFF_CTRL, 32'h3);
		wr(OFF_MP, 32'hF05A);
		rxq('{9'h153, 9'h011, 9'h1A5, 9'h022});
		creg(OFF_FIFO, 32'h1F, 32'h2);
		creg(OFF_RX_DATA, 32'h1FF, 32'h153);
		creg(OFF_RX_DATA, 32'h1FF, 32'h011);
		wr(OFF_CTRL, 32'h1);
		rxq('{9'h15F, 9'h033});
		creg(OFF_RX_DATA, 32'h1FF, 32'h033);
		creg(OFF_FIFO, 32'h1F, 32'h0);
		wr(OFF_CTRL, 32'h0);
		rxq('{9'h1A5});
		creg(OFF_RX_DATA, 32'h1FF, 32'h1A5);
	endtask : t_mp

	task automatic t_cts();
		@(posedge mclk);
		cts_in <= 1'b1;
		wr(OFF_CTRL, 32'h8);
		wr(OFF_TX_DATA, 32'h05A);
		txp(0);
		@(posedge mclk);
		cts_in <= 1'b0;
		txp(1);
		cmp(u_peer.last, 32'h05A);
		wr(OFF_CTRL, 32'h18);
		wr(OFF_TX_DATA, 32'h0C3);
		txp(1);
		@(posedge mclk);
		cts_in <= 1'b1;
		txp(2);
		wr(OFF_CTRL, 32'h0);
		wr(OFF_TX_DATA, 32'h111);
		txp(3);
		cmp(u_peer.last, 32'h111);
	endtask : t_cts

	task automatic t_byte();
		wr(OFF_CTRL, 32'h4);
		for (int i = 0; i < 17; i++) wr(OFF_TX_DATA, 32'(i));
		creg(OFF_FIFO, 32'h1F00, 32'(DEPTH_BYTE) << 8);
		creg(OFF_TX_STAT, 32'h08, 32'h08);
		for (int i = 0; i < 15; i++) u_peer.evt(4'h8);
		txp(19);
		cmp(u_peer.last, 32'h00F);
		u_peer.evt(4'h8);
		creg(OFF_TX_STAT, 32'h10, 32'h10);
		wr(OFF_TX_STAT, 32'hFF);
		wr(OFF_CTRL, 32'h0);
	endtask : t_byte

	task automatic t_irq();
		wr(OFF_RX_TRIG, 32'h3);
		wr(OFF_TX_TRIG, 32'h5);
		creg(OFF_RX_TRIG, 32'hF, 32'h3);
		creg(OFF_TX_TRIG, 32'hF, 32'h5);
		wr(OFF_RX_MASK, 32'h22);
		u_peer.send(9'h0AA, 1'b1);
		nx(3);
		cmp(irq, 1'b0);
		creg(OFF_RX_STAT, 32'h22, 32'h22);
		creg(OFF_RX_MASK, 32'hFF, 32'h22);
		wr(OFF_CTRL, 32'h40);
		nx(3);
		cmp(irq, 1'b1);
		rd(OFF_RX_DATA, RESP_OKAY, d);
		wr(OFF_RX_STAT, 32'h3F);
		nx(3);
		cmp(irq, 1'b0);
		wr(OFF_TX_MASK, 32'hE0);
		for (int i = 0; i < 3; i++) begin
			u_peer.evt(4'h4 >> i);
			nx(3);
			cmp(irq, 1'b1);
			creg(OFF_TX_STAT, 32'hE0, 32'h20 << i);
			wr(OFF_TX_STAT, 32'hE0);
			nx(3);
			cmp(irq, 1'b0);
		end
	endtask : t_irq

	task automatic t_ce();
		@(posedge mclk);
		ce <= 1'b0;
		u_peer.send(9'h055, 1'b0);
		ce <= 1'b1;
		creg(OFF_FIFO, 32'h1F, 32'h0);
		creg(OFF_RX_STAT, 32'h02, 32'h0);
	endtask : t_ce

	initial begin
		mclk = 1'b0;
		rst = 1'b1;
		ce = 1'b1;
		cts_in = 1'b0;
		req = '0;
		fails = 0;
		compares = 0;
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		nx(1);
		t_reset();
		t_rts();
		t_ovf();
		t_mp();
		t_cts();
		t_byte();
		t_irq();
		t_ce();
		finish_test();
	end
endmodule : umf_uart_ctrl_tb
